/* verilog/lcp_pkg.sv */
// Constants shared by the LED controller pin, clock and reset logic.
package lcp_pkg;
   // =========================================================================
   // Register map, byte addresses on the Wishbone bus.
   localparam logic [7:0] LCP_CTRL_ADDR = 8'h00;
   localparam logic [7:0] LCP_GPO_ADDR = 8'h04;
   localparam logic [7:0] LCP_STATUS_ADDR = 8'h08;
   localparam logic [7:0] LCP_SYNC_PULSE_PIN_ADDR = 8'h0c;
   localparam logic [7:0] LCP_RESET_ADDR = 8'h10;
   localparam logic [7:0] LCP_BUSADDR_ADDR = 8'h14;
   // =========================================================================
   // Field positions.
   localparam int LCP_CTRL_CHIP_EN = 0;
   localparam int LCP_CTRL_INT_CLK = 1;
   localparam int LCP_CTRL_DET_ON = 2;
   localparam int LCP_GPO_GENERAL = 0;
   localparam int LCP_GPO_ALERT_SEL = 1;
   localparam int LCP_GPO_ALERT_BIT = 2;
   localparam int LCP_ST_EXT_USED = 0;
   localparam int LCP_ST_ALERT = 1;
   localparam int LCP_ST_SYNC_SEEN = 2;
   localparam int LCP_ST_EN_PIN = 3;
   localparam int LCP_SYNC_PULSE_PIN_SEND = 0;
   // =========================================================================
   // Reset values and magic numbers.
   localparam logic [2:0] LCP_CTRL_RESET = 3'h0;
   localparam logic [2:0] LCP_GPO_RESET = 3'h0;
   localparam logic [7:0] LCP_RESET_KEY = 8'hff;
   localparam logic [3:0] LCP_GROUP_ID = 4'h6;
   // =========================================================================
   // Timing.
   localparam int LCP_SYS_HZ = 125000000;
   localparam int LCP_INT_OSC_HZ = 32768;
   localparam int LCP_EXT_MIN_HZ = 15000;
   localparam int LCP_INT_DIV = LCP_SYS_HZ / LCP_INT_OSC_HZ;
   localparam int LCP_EXT_TIMEOUT = LCP_SYS_HZ / LCP_EXT_MIN_HZ;
   localparam logic [1:0] LCP_SYNC_MIN_TICKS = 2'h2;
   localparam logic [1:0] LCP_SYNC_OUT_TICKS = 2'h3;
   localparam logic [1:0] LCP_EXT_GOOD_EDGES = 2'h2;
   // =========================================================================
   // Source selection state.
   typedef enum logic [0:0] {
      LCP_SRC_INT = 1'b0,
      LCP_SRC_EXT = 1'b1
   } lcp_src_type;
endpackage

/* verilog/lcp_clk_detect.sv */
// Presence detector for the outside slow clock.
`timescale 1ns/1ps
module lcp_clk_detect
   import lcp_pkg::*;
#(
   parameter int TIMEOUT = LCP_EXT_TIMEOUT
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_clear,
   input wire logic i_hold,
   input wire logic i_rise,
   output logic o_present
);
   // =========================================================================
   // Time since the last rising edge; too long means slow or stuck.
   logic [15:0] gap_r;
   logic [1:0] good_r;
   logic timeout;

   assign timeout = (gap_r >= 16'(TIMEOUT));

   // Counts cycles between rising edges, frozen while held.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         gap_r <= 16'h0000;
      end else if (i_clear || i_rise) begin
         gap_r <= 16'h0000;
      end else if (!i_hold && !timeout) begin
         gap_r <= gap_r + 16'h0001;
      end
   end

   // Declares presence after a run of timely edges, loss on timeout.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         good_r <= 2'h0;
         o_present <= 1'b0;
      end else if (i_clear) begin
         good_r <= 2'h0;
         o_present <= 1'b0;
      end else if (!i_hold) begin
         if (timeout) begin
            good_r <= 2'h0;
            o_present <= 1'b0;
         end else if (i_rise) begin
            if (good_r == LCP_EXT_GOOD_EDGES) begin
               o_present <= 1'b1;
            end else begin
               good_r <= good_r + 2'h1;
            end
         end
      end
   end
endmodule // lcp_clk_detect

/* verilog/lcp_top.sv */
// Pin, clock source and reset logic of the LED controller, Wishbone slave.
`timescale 1ns/1ps
module lcp_top
   import lcp_pkg::*;
#(
   parameter int EXT_TIMEOUT = LCP_EXT_TIMEOUT
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_en_pin,
   input wire logic i_bus_address_pin0,
   input wire logic i_bus_address_pin1,
   input wire logic i_external_slow_clock_pin,
   input wire logic i_sync_pulse_pin,
   input wire logic i_end_with_alert,
   input wire logic i_sync_send,
   input wire logic i_power_save,
   output logic o_general_output_bit,
   output logic o_alert_out,
   output logic o_alert_oe,
   output logic o_sync_pulse_pin_out,
   output logic o_sync_pulse_pin_oe,
   output logic o_sync_received,
   output logic o_exec_tick,
   output logic o_osc_enable,
   output logic o_chip_en,
   output logic o_standby,
   output logic [6:0] o_bus_address
);
   // =========================================================================
   // Input synchronisers for every pin from outside this clock.
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic ext_prev_r;
   logic en_now;
   logic ext_now;
   logic sync_line;
   logic ext_rise;

   // Two flops per pin; only the second stage feeds logic.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_meta_r <= 4'h0;
         pin_sync_r <= 4'h0;
         ext_prev_r <= 1'b0;
      end else begin
         pin_meta_r <= {i_bus_address_pin1, i_external_slow_clock_pin,
                        i_sync_pulse_pin, i_en_pin};
         pin_sync_r <= pin_meta_r;
         ext_prev_r <= pin_sync_r[2];
      end
   end

   assign en_now = pin_sync_r[0];
   assign sync_line = pin_sync_r[1];
   assign ext_now = pin_sync_r[2];
   assign ext_rise = ext_now && !ext_prev_r;

   logic addr0_meta_r;
   logic addr0_sync_r;

   // First address pin gets its own pair of flops.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         addr0_meta_r <= 1'b0;
         addr0_sync_r <= 1'b0;
      end else begin
         addr0_meta_r <= i_bus_address_pin0;
         addr0_sync_r <= addr0_meta_r;
      end
   end

   // =========================================================================
   // Shutdown and software reset.
   logic soft_rst_r;
   logic clr;
   logic wr_strobe;
   logic rd_strobe;

   // Enable pin low holds everything cleared; so does a software reset.
   assign clr = soft_rst_r || !en_now;
   assign wr_strobe = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack &&
                      i_wb_sel[0] && en_now;
   assign rd_strobe = i_wb_cyc && i_wb_stb && !o_wb_ack;

   // A write of the key to the reset register clears all registers.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_strobe && (i_wb_adr == LCP_RESET_ADDR) &&
                       (i_wb_dat[7:0] == LCP_RESET_KEY);
      end
   end

   // =========================================================================
   // Control and general output registers.
   logic [2:0] ctrl_r;
   logic [2:0] gpo_r;

   // Power-up clear and soft reset return defaults; chip-on reads zero.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl_r <= LCP_CTRL_RESET;
         gpo_r <= LCP_GPO_RESET;
      end else if (clr) begin
         ctrl_r <= LCP_CTRL_RESET;
         gpo_r <= LCP_GPO_RESET;
      end else if (wr_strobe && i_wb_adr == LCP_CTRL_ADDR) begin
         ctrl_r <= i_wb_dat[2:0];
      end else if (wr_strobe && i_wb_adr == LCP_GPO_ADDR) begin
         gpo_r <= i_wb_dat[2:0];
      end
   end

   // =========================================================================
   // Clock source selection and execution tick.
   logic ext_present;
   lcp_src_type src;
   logic [11:0] div_r;
   logic int_tick;

   lcp_clk_detect #(
      .TIMEOUT(EXT_TIMEOUT)
   ) u_detect (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_clear(clr || !ctrl_r[LCP_CTRL_DET_ON]),
      .i_hold(i_power_save),
      .i_rise(ext_rise),
      .o_present(ext_present)
   );

   // Auto-detect wins over the manual internal select bit.
   always_comb begin
      if (ctrl_r[LCP_CTRL_DET_ON]) begin
         src = ext_present ? LCP_SRC_EXT : LCP_SRC_INT;
      end else begin
         src = ctrl_r[LCP_CTRL_INT_CLK] ? LCP_SRC_INT : LCP_SRC_EXT;
      end
   end

   assign int_tick = (div_r == 12'(LCP_INT_DIV - 1));

   // Internal oscillator model: divider runs unless stopped for power save or by the enable pin low.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_r <= 12'h000;
      end else if (int_tick || !o_osc_enable) begin
         div_r <= 12'h000;
      end else begin
         div_r <= div_r + 12'h001;
      end
   end

   // Tick follows the chosen source, so timing scales with it.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_exec_tick <= 1'b0;
      end else if (src == LCP_SRC_EXT) begin
         o_exec_tick <= ext_rise && en_now;
      end else begin
         o_exec_tick <= int_tick && en_now;
      end
   end

   // Oscillator stops while the outside clock runs the engine in power save.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_osc_enable <= 1'b1;
      end else begin
         o_osc_enable <= en_now &&
                         !(src == LCP_SRC_EXT && i_power_save);
      end
   end

   // =========================================================================
   // Sync pulse receive and transmit, measured in execution ticks.
   logic [1:0] rx_cnt_r;
   logic [1:0] tx_cnt_r;
   logic tx_pend_r;
   logic sync_seen_r;
   logic alert_pend_r;
   logic st_wr;

   assign st_wr = wr_strobe && (i_wb_adr == LCP_STATUS_ADDR);

   // Line low is sampled on each tick; own pulse is not counted.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_cnt_r <= 2'h0;
         o_sync_received <= 1'b0;
      end else if (clr) begin
         rx_cnt_r <= 2'h0;
         o_sync_received <= 1'b0;
      end else begin
         o_sync_received <= 1'b0;
         if (o_exec_tick) begin
            if (sync_line || o_sync_pulse_pin_oe) begin
               rx_cnt_r <= 2'h0;
            end else if (rx_cnt_r != LCP_SYNC_MIN_TICKS) begin
               rx_cnt_r <= rx_cnt_r + 2'h1;
               o_sync_received <= (rx_cnt_r + 2'h1 ==
                                   LCP_SYNC_MIN_TICKS);
            end
         end
      end
   end

   // Request latched, then line pulled low for three whole ticks.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_pend_r <= 1'b0;
         tx_cnt_r <= 2'h0;
         o_sync_pulse_pin_oe <= 1'b0;
      end else if (clr) begin
         tx_pend_r <= 1'b0;
         tx_cnt_r <= 2'h0;
         o_sync_pulse_pin_oe <= 1'b0;
      end else begin
         if (o_exec_tick) begin
            if (o_sync_pulse_pin_oe) begin
               if (tx_cnt_r == LCP_SYNC_OUT_TICKS - 2'h1) begin
                  o_sync_pulse_pin_oe <= 1'b0;
                  tx_cnt_r <= 2'h0;
               end else begin
                  tx_cnt_r <= tx_cnt_r + 2'h1;
               end
            end else if (tx_pend_r) begin
               o_sync_pulse_pin_oe <= 1'b1;
               tx_pend_r <= 1'b0;
            end
         end
         // A request in the cycle a pulse starts stays pending.
         if (i_sync_send ||
             (wr_strobe && i_wb_adr == LCP_SYNC_PULSE_PIN_ADDR &&
              i_wb_dat[LCP_SYNC_PULSE_PIN_SEND])) begin
            tx_pend_r <= 1'b1;
         end
      end
   end

   // Line only ever pulled low.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_sync_pulse_pin_out <= 1'b0;
      end else begin
         o_sync_pulse_pin_out <= 1'b0;
      end
   end

   // Sticky status flags; a new event beats a clear in the same cycle.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_seen_r <= 1'b0;
         alert_pend_r <= 1'b0;
      end else if (clr) begin
         sync_seen_r <= 1'b0;
         alert_pend_r <= 1'b0;
      end else begin
         if (o_sync_received) begin
            sync_seen_r <= 1'b1;
         end else if (st_wr && i_wb_dat[LCP_ST_SYNC_SEEN]) begin
            sync_seen_r <= 1'b0;
         end
         if (i_end_with_alert) begin
            alert_pend_r <= 1'b1;
         end else if (st_wr && i_wb_dat[LCP_ST_ALERT]) begin
            alert_pend_r <= 1'b0;
         end
      end
   end

   // =========================================================================
   // Output pins and bus address.
   // General output, alert pin in its two roles, chip state.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_general_output_bit <= 1'b0;
         o_alert_out <= 1'b0;
         o_alert_oe <= 1'b0;
         o_chip_en <= 1'b0;
         o_standby <= 1'b0;
         o_bus_address <= 7'h00;
      end else begin
         o_general_output_bit <= gpo_r[LCP_GPO_GENERAL];
         if (gpo_r[LCP_GPO_ALERT_SEL]) begin
            o_alert_out <= gpo_r[LCP_GPO_ALERT_BIT];
            o_alert_oe <= 1'b1;
         end else begin
            o_alert_out <= 1'b0;
            o_alert_oe <= alert_pend_r && !clr;
         end
         o_chip_en <= ctrl_r[LCP_CTRL_CHIP_EN];
         o_standby <= en_now && !ctrl_r[LCP_CTRL_CHIP_EN];
         o_bus_address <= {LCP_GROUP_ID,
                           3'({pin_sync_r[3], addr0_sync_r}) +
                           3'h2};
      end
   end

   // =========================================================================
   // Wishbone answer: ack one cycle after the strobe, dropped next cycle.
   logic [31:0] rd_data;

   // Read mux; unmapped addresses read zero.
   always_comb begin
      rd_data = 32'h00000000;
      unique case (i_wb_adr)
         LCP_CTRL_ADDR: rd_data[2:0] = ctrl_r;
         LCP_GPO_ADDR: rd_data[2:0] = gpo_r;
         LCP_STATUS_ADDR: begin
            rd_data[LCP_ST_EXT_USED] = (src == LCP_SRC_EXT);
            rd_data[LCP_ST_ALERT] = alert_pend_r;
            rd_data[LCP_ST_SYNC_SEEN] = sync_seen_r;
            rd_data[LCP_ST_EN_PIN] = en_now;
         end
         LCP_BUSADDR_ADDR: rd_data[6:0] = o_bus_address;
         default: rd_data = 32'h00000000;
      endcase
   end

   // Single-cycle registered answer to every access, mapped or not.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
      end else begin
         o_wb_ack <= rd_strobe;
         if (rd_strobe && !i_wb_we && en_now) begin
            o_wb_dat <= rd_data;
         end else if (rd_strobe) begin
            o_wb_dat <= 32'h00000000;
         end
      end
   end
endmodule // lcp_top

/* tb/lcp_top_sva.sv */
// Port-level checker of the pin, clock source and bus logic.
`timescale 1ns/1ps
module lcp_top_sva
   import lcp_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic o_wb_ack,
   input wire logic i_en_pin,
   input wire logic i_bus_address_pin0,
   input wire logic i_bus_address_pin1,
   input wire logic i_end_with_alert,
   input wire logic o_general_output_bit,
   input wire logic o_alert_oe,
   input wire logic o_sync_pulse_pin_out,
   input wire logic o_sync_pulse_pin_oe,
   input wire logic o_exec_tick,
   input wire logic o_chip_en,
   input wire logic o_standby,
   input wire logic [6:0] o_bus_address
);
   logic [2:0] ticks_r;
   logic [2:0] up_r;
   // ==========================================================
   // Counts slow ticks while this controller pulls the sync line, and time out of reset.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ticks_r <= 3'h0;
         up_r <= 3'h0;
      end else begin
         ticks_r <= !o_sync_pulse_pin_oe ? 3'h0 : ticks_r + 3'(o_exec_tick);
         up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      end
   end
   default clocking dcb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);
   // ==========================================================
   // Steps of a bus write and a settled address-pin setting.
   sequence take_s;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence gpo_wr_s;
      o_wb_ack && i_wb_cyc && i_wb_we && i_wb_sel[0] && i_en_pin
         && i_wb_adr == LCP_GPO_ADDR;
   endsequence
   sequence addr_calm_s;
      $stable({i_en_pin, i_bus_address_pin1, i_bus_address_pin0}) [*5]
         ##0 i_en_pin && up_r == 3'h7;
   endsequence
   // ==========================================================
   // Assertions.
   ack_latency_a: assert property (take_s |=> o_wb_ack)
      else $error("bus request not answered after one cycle");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("bus ack longer than one cycle");
   gpo_follow_a: assert property (
      gpo_wr_s |-> ##2 o_general_output_bit == $past(i_wb_dat[0], 2))
      else $error("general output pin does not follow its bit");
   alert_pull_a: assert property (
      i_end_with_alert && i_en_pin |-> ##[1:3] o_alert_oe)
      else $error("alert pin not pulled after flagged end");
   sync_drain_a: assert property (!o_sync_pulse_pin_out)
      else $error("sync pin driven high");
   sync_length_a: assert property (
      $fell(o_sync_pulse_pin_oe) |-> ticks_r == 3'h3)
      else $error("sent sync pulse not three slow ticks long");
   bus_addr_a: assert property (
      addr_calm_s |-> o_bus_address == {4'h6,
         3'({i_bus_address_pin1, i_bus_address_pin0}) + 3'h2})
      else $error("bus address does not match the select pins");
   standby_a: assert property (o_standby |-> !o_chip_en)
      else $error("standby while chip enabled");
   shutdown_a: assert property (
      !i_en_pin [*5] |-> !o_chip_en && !o_standby && !o_general_output_bit)
      else $error("functions still active with enable pin low");
endmodule // lcp_top_sva

bind lcp_top lcp_top_sva chk_u (.*);

/* tb/lcp_peer_model.sv */
// Peer controller on the shared sync line, and the outside slow clock.
`timescale 1ns/1ps
module lcp_peer_model (
   input wire logic i_clk_run,
   input wire logic i_dut_oe,
   output logic o_slow_clk,
   output logic o_line
);
   logic pull_r;
   // ==========================================================
   // Outside slow clock of 80 ns; when stopped it stays at its level.
   initial begin
      o_slow_clk = 1'b0;
      pull_r = 1'b0;
   end
   always begin
      #40;
      if (i_clk_run) begin
         o_slow_clk = ~o_slow_clk;
      end
   end
   // The line has a pull-up, so it is low while any party pulls it.
   assign o_line = !(i_dut_oe || pull_r);
   // Pulls the line low for a whole number of slow clock cycles.
   task automatic send(input int cycles);
      @(posedge o_slow_clk);
      pull_r <= 1'b1;
      repeat (cycles) @(posedge o_slow_clk);
      pull_r <= 1'b0;
   endtask
endmodule // lcp_peer_model

/* tb/test_led_ctrl_pins_clock_reset.sv */
// Self-checking bench of the pin, clock source and reset logic.
`timescale 1ns/1ps
module test_led_ctrl_pins_clock_reset
   import lcp_pkg::*;
;
   localparam int TMO = 200;
   localparam int LIMIT = 30000;
   logic i_sys_clk = 1'b0, i_rstn = 1'b0;
   logic i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
   logic i_en_pin = 1'b1, i_bus_address_pin0 = 1'b0, i_bus_address_pin1 = 1'b0;
   logic i_end_with_alert = 1'b0, i_sync_send = 1'b0, i_power_save = 1'b0;
   logic [7:0] i_wb_adr = 8'h00;
   logic [3:0] i_wb_sel = 4'hf;
   logic [31:0] i_wb_dat = 32'h0, o_wb_dat;
   logic o_wb_ack, o_general_output_bit, o_alert_out, o_alert_oe;
   logic o_sync_pulse_pin_out, o_sync_pulse_pin_oe, o_sync_received;
   logic o_exec_tick, o_osc_enable, o_chip_en, o_standby;
   logic [6:0] o_bus_address;
   logic i_external_slow_clock_pin, i_sync_pulse_pin, clk_run = 1'b1;
   int errors = 0, check_count = 0, cycles = 0, rx_count = 0;

   lcp_top #(.EXT_TIMEOUT(TMO)) dut_u (.*);
   lcp_peer_model peer_u (.i_clk_run(clk_run), .i_dut_oe(o_sync_pulse_pin_oe),
      .o_slow_clk(i_external_slow_clock_pin), .o_line(i_sync_pulse_pin));

   // ==========================================================
   // Clock, cycle limit and count of recognised sync pulses.
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (o_sync_received === 1'b1) begin
         rx_count <= rx_count + 1;
      end
      if (cycles == LIMIT) begin
         errors++;
         print_verdict();
      end
   end

   // ==========================================================
   // Shared tasks.
   task automatic idle(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   task automatic check(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
      @(posedge i_sys_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= w;
      i_wb_adr <= a;
      i_wb_dat <= {24'h0, d};
      @(posedge i_sys_clk);
      while (o_wb_ack !== 1'b1) begin
         @(posedge i_sys_clk);
      end
      q = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      check(nm, e, q);
   endtask
   task automatic ext_used(input logic e);
      logic [31:0] q;
      wb(1'b0, LCP_STATUS_ADDR, 8'h00, q);
      check("clock source", {31'h0, e}, {31'h0, q[LCP_ST_EXT_USED]});
   endtask
   // Cycles from one slow tick to the next.
   task automatic tick_period(output int p);
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         @(posedge i_sys_clk);
         while (o_exec_tick !== 1'b1 && n < 9000) begin
            @(posedge i_sys_clk);
            n++;
         end
      end
      p = n + 1;
   endtask
   task automatic print_verdict();
      $display("Checks %0d, errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Test sequence.
   initial begin
      int p, rx0;
      idle(5);
      i_rstn <= 1'b1;
      idle(5);
      rd("ctrl", LCP_CTRL_ADDR, 32'h0);
      rd("gpo", LCP_GPO_ADDR, 32'h0);
      rd("status", LCP_STATUS_ADDR, 32'h9);
      rd("unmapped", 8'h20, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {i_bus_address_pin1, i_bus_address_pin0} <= 2'(i);
         idle(6);
         rd("bus address", LCP_BUSADDR_ADDR,
            {25'h0, 4'h6, 3'(i + 2)});
      end
      // Alert pin as interrupt, then as general output.
      wr(LCP_GPO_ADDR, 8'h05);
      idle(2);
      check("gpo pin", 32'h1, o_general_output_bit);
      check("alert idle", 32'h0, o_alert_oe);
      i_end_with_alert <= 1'b1;
      idle(1);
      i_end_with_alert <= 1'b0;
      idle(3);
      check("alert pull", 32'h1, {o_alert_out, o_alert_oe});
      wr(LCP_STATUS_ADDR, 8'h02);
      idle(2);
      check("alert clear", 32'h0, o_alert_oe);
      wr(LCP_GPO_ADDR, 8'h06);
      idle(2);
      check("alert high", 32'h3, {o_alert_out, o_alert_oe});
      wr(LCP_GPO_ADDR, 8'h02);
      idle(2);
      check("alert low", 32'h1, {o_alert_out, o_alert_oe});
      // Sync pulses on the outside clock.
      rx0 = rx_count;
      i_sync_send <= 1'b1;
      idle(1);
      i_sync_send <= 1'b0;
      idle(20);
      check("line pulled", 32'h0, i_sync_pulse_pin);
      idle(60);
      check("send over", 32'h0, o_sync_pulse_pin_oe);
      check("own pulse", rx0, rx_count);
      peer_u.send(1);
      idle(40);
      check("short sync", rx0, rx_count);
      peer_u.send(2);
      idle(40);
      check("long sync", rx0 + 1, rx_count);
      rd("sync seen", LCP_STATUS_ADDR, 32'hd);
      // Clock source selection.
      tick_period(p);
      check("ext period", 32'd10, p);
      wr(LCP_CTRL_ADDR, 8'h02);
      ext_used(1'b0);
      tick_period(p);
      check("int period", LCP_INT_DIV, p);
      wr(LCP_CTRL_ADDR, 8'h04);
      idle(60);
      ext_used(1'b1);
      clk_run <= 1'b0;
      idle(100);
      ext_used(1'b1);
      idle(150);
      ext_used(1'b0);
      clk_run <= 1'b1;
      idle(60);
      ext_used(1'b1);
      i_power_save <= 1'b1;
      idle(4);
      check("osc stop", 32'h0, o_osc_enable);
      clk_run <= 1'b0;
      idle(300);
      ext_used(1'b1);
      i_power_save <= 1'b0;
      idle(4);
      check("osc run", 32'h1, o_osc_enable);
      idle(250);
      ext_used(1'b0);
      clk_run <= 1'b1;
      // Soft reset, standby and shutdown.
      wr(LCP_GPO_ADDR, 8'h01);
      wr(LCP_CTRL_ADDR, 8'h01);
      idle(2);
      check("chip on", 32'h2, {o_chip_en, o_standby});
      wr(LCP_RESET_ADDR, 8'hfe);
      rd("wrong key", LCP_CTRL_ADDR, 32'h1);
      wr(LCP_RESET_ADDR, 8'hff);
      idle(2);
      check("soft reset", 32'h2,
            {o_chip_en, o_standby, o_general_output_bit});
      rd("ctrl cleared", LCP_CTRL_ADDR, 32'h0);
      wr(LCP_CTRL_ADDR, 8'h01);
      i_en_pin <= 1'b0;
      idle(6);
      check("shutdown", 32'h0, {o_chip_en, o_standby});
      wr(LCP_CTRL_ADDR, 8'h01);
      rd("ctrl shut", LCP_CTRL_ADDR, 32'h0);
      i_en_pin <= 1'b1;
      idle(6);
      rd("ctrl after", LCP_CTRL_ADDR, 32'h0);
      print_verdict();
   end
endmodule // test_led_ctrl_pins_clock_reset
